// ==== src/lsd_defines.svh ====
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

// register offsets on the serial control port
`define LSD_OFS_SLOT_SELECT   8'h14
`define LSD_OFS_DRV3_CFG      8'h22
`define LSD_OFS_DRV1_CFG      8'h23

// reset values
`define LSD_RST_SLOT_SELECT   16'h0541
`define LSD_RST_DRV_CFG       16'h3000
`define LSD_RST_FIRST_CHOICE  2'h1
`define LSD_RST_SECOND_CHOICE 2'h0
`define LSD_RST_FIRST_ROUTE   4'h4
`define LSD_RST_SECOND_ROUTE  4'h5
`define LSD_RST_SCALE         1'h1

// slot select field positions
`define LSD_FIRST_CHOICE_LSB  0
`define LSD_SECOND_CHOICE_LSB 2
`define LSD_FIRST_ROUTE_LSB   4
`define LSD_SECOND_ROUTE_LSB  8

// driver config field positions
`define LSD_SCALE_BIT         13
`define LSD_SLEW_LSB          4
`define LSD_COARSE_LSB        0

// coarse term in 0.1 mA, fine in 0.001, scale in 0.1
`define LSD_COARSE_BASE       12'h1F7
`define LSD_COARSE_STEP       12'h0C6
`define LSD_FINE_BASE         11'h2E4
`define LSD_FINE_STEP         11'h016
`define LSD_SCALE_LOW         4'h1
`define LSD_SCALE_STEP        4'h9

// read data and valid answer one edge after the read strobe
`define LSD_READ_LATENCY      1

`endif

// ==== src/lsd_pkg.sv ====
`include "lsd_defines.svh"

package lsd_pkg;

   typedef logic [15:0] lsd_word_t;
   typedef logic [11:0] lsd_coarse_t;
   typedef logic [10:0] lsd_fine_t;
   typedef logic [25:0] lsd_peak_t;

   typedef enum logic [1:0] {
      LSD_EMIT_DETECTOR = 2'h0,
      LSD_EMIT_DRIVER1  = 2'h1,
      LSD_EMIT_DRIVER2  = 2'h2,
      LSD_EMIT_DRIVER3  = 2'h3
   } lsd_emit_e;

   // one-hot driver enable, bit 0 is driver one
   function automatic logic [2:0] lsd_emit_onehot(input logic [1:0] choice);
      logic [2:0] hot;
      hot = 3'h0;
      unique case (lsd_emit_e'(choice))
         LSD_EMIT_DETECTOR: hot = 3'h0;
         LSD_EMIT_DRIVER1:  hot = 3'h1;
         LSD_EMIT_DRIVER2:  hot = 3'h2;
         LSD_EMIT_DRIVER3:  hot = 3'h4;
      endcase
      return hot;
   endfunction : lsd_emit_onehot

   function automatic lsd_coarse_t lsd_coarse_term(input logic [3:0] code);
      logic [15:0] prod;
      prod = 16'(`LSD_COARSE_BASE) + 16'(`LSD_COARSE_STEP) * 16'(code);
      return prod[11:0];
   endfunction : lsd_coarse_term

endpackage : lsd_pkg

// ==== src/lsd_slot_decode.sv ====
`timescale 1ns/1ps
`include "lsd_defines.svh"

module lsd_slot_decode #(
   parameter logic [1:0] RESET_CHOICE = 2'h0,
   parameter logic [3:0] RESET_ROUTE  = 4'h0
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] emitter_choice,
   input  wire logic [3:0] detector_route_sel,
   output logic      [2:0] emitter_enable,
   output logic            detector_pulse,
   output logic      [3:0] detector_route
);

   logic [2:0] next_emitter_enable;
   logic       next_detector_pulse;
   logic [3:0] next_detector_route;

   always_comb begin
      next_emitter_enable = lsd_pkg::lsd_emit_onehot(emitter_choice);
      // code zero pulses the photodiode path instead of an emitter
      next_detector_pulse = (emitter_choice == lsd_pkg::LSD_EMIT_DETECTOR);
      next_detector_route = detector_route_sel;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         emitter_enable <= lsd_pkg::lsd_emit_onehot(RESET_CHOICE);
         detector_pulse <= (RESET_CHOICE == 2'h0);
         detector_route <= RESET_ROUTE;
      end else begin
         emitter_enable <= next_emitter_enable;
         detector_pulse <= next_detector_pulse;
         detector_route <= next_detector_route;
      end
   end

endmodule : lsd_slot_decode

// ==== src/lsd_peak_calc.sv ====
`timescale 1ns/1ps
`include "lsd_defines.svh"

module lsd_peak_calc (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  coarse_code,
   input  wire logic [4:0]  fine_code,
   input  wire logic        strength_bit,
   output lsd_pkg::lsd_coarse_t coarse_term,
   output lsd_pkg::lsd_peak_t   peak_target
);

   lsd_pkg::lsd_coarse_t next_coarse_term;
   lsd_pkg::lsd_fine_t   fine_term;
   logic [3:0]           scale_term;
   logic [26:0]          product;
   lsd_pkg::lsd_peak_t   next_peak_target;

   // peak in units of 1e-5 mA; widest value fits 26 bits
   always_comb begin
      next_coarse_term = lsd_pkg::lsd_coarse_term(coarse_code);
      fine_term = `LSD_FINE_BASE + `LSD_FINE_STEP * 11'(fine_code);
      scale_term = `LSD_SCALE_LOW + (strength_bit ? `LSD_SCALE_STEP : 4'h0);
      product = 27'(next_coarse_term) * 27'(fine_term) * 27'(scale_term);
      next_peak_target = product[25:0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         coarse_term <= 12'h000;
         peak_target <= 26'h0000000;
      end else begin
         coarse_term <= next_coarse_term;
         peak_target <= next_peak_target;
      end
   end

endmodule : lsd_peak_calc

// ==== src/lsd_drive_config.sv ====
// Contract
// - slot A code picks driver, resets 1
// - slot B same mapping, resets 0
// - code zero pulses photodiode path instead
// - slot A photodiode route, resets 4
// - slot B photodiode route, resets 5
// - driver 3 scale: full or tenth, resets set
// - driver 1 scale: full or tenth, resets set
// - driver 3 slew, slowest 0, resets 0
// - driver 3 coarse term 50.3 plus 19.8*code
// - driver 3 peak is coarse*fine*scale
// - driver 3 fine is 0.74 plus 0.022*code
// - driver 1 coarse term 50.3 plus 19.8*code
`timescale 1ns/1ps
`include "lsd_defines.svh"

module lsd_drive_config #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_rd,
   output logic      [15:0]       reg_rdata,
   output logic                   reg_rvalid,
   input  wire logic [4:0]        driver3_fine_code,
   output logic      [2:0]        first_slot_emitter_enable,
   output logic                   first_slot_detector_pulse,
   output logic      [3:0]        first_slot_detector_route,
   output logic      [2:0]        second_slot_emitter_enable,
   output logic                   second_slot_detector_pulse,
   output logic      [3:0]        second_slot_detector_route,
   output logic                   driver3_strength_bit,
   output logic      [2:0]        driver3_edge_speed,
   output logic      [3:0]        driver3_coarse_code,
   output logic      [11:0]       driver3_coarse_term,
   output logic      [25:0]       driver3_peak_target,
   output logic                   driver1_strength_bit,
   output logic      [3:0]        driver1_coarse_code,
   output logic      [11:0]       driver1_coarse_term
);

   // offsets up to led1_drive_config must be reachable
   if (ADDR_W < 6 || ADDR_W > 16) begin : g_bad_addr_w
      $error("lsd_drive_config: ADDR_W must lie between 6 and 16");
   end

   lsd_pkg::lsd_word_t slot_select;
   lsd_pkg::lsd_word_t drv3_cfg;
   lsd_pkg::lsd_word_t drv1_cfg;
   lsd_pkg::lsd_word_t next_slot_select;
   lsd_pkg::lsd_word_t next_drv3_cfg;
   lsd_pkg::lsd_word_t next_drv1_cfg;
   lsd_pkg::lsd_word_t next_reg_rdata;
   logic               next_reg_rvalid;
   logic [11:0]        next_driver1_coarse_term;

   // address match, shared by the write and the read paths
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        ofs);
      return addr == ADDR_W'(ofs);
   endfunction : addr_hit

   // register writes; reserved bits are stored as written, keeping
   // them at their defaults is the host's duty
   always_comb begin
      next_slot_select = slot_select;
      next_drv3_cfg    = drv3_cfg;
      next_drv1_cfg    = drv1_cfg;
      if (reg_wr) begin
         if (addr_hit(reg_addr, `LSD_OFS_SLOT_SELECT)) begin
            next_slot_select = reg_wdata;
         end
         if (addr_hit(reg_addr, `LSD_OFS_DRV3_CFG)) begin
            next_drv3_cfg = reg_wdata;
         end
         if (addr_hit(reg_addr, `LSD_OFS_DRV1_CFG)) begin
            next_drv1_cfg = reg_wdata;
         end
      end
   end

   // read path; a read in the same cycle as a write returns the old value
   always_comb begin
      next_reg_rdata  = reg_rdata;
      next_reg_rvalid = reg_rd;
      if (reg_rd) begin
         if (addr_hit(reg_addr, `LSD_OFS_SLOT_SELECT)) begin
            next_reg_rdata = slot_select;
         end else if (addr_hit(reg_addr, `LSD_OFS_DRV3_CFG)) begin
            next_reg_rdata = drv3_cfg;
         end else if (addr_hit(reg_addr, `LSD_OFS_DRV1_CFG)) begin
            next_reg_rdata = drv1_cfg;
         end else begin
            next_reg_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slot_select <= `LSD_RST_SLOT_SELECT;
         drv3_cfg    <= `LSD_RST_DRV_CFG;
         drv1_cfg    <= `LSD_RST_DRV_CFG;
         reg_rdata   <= 16'h0000;
         reg_rvalid  <= 1'b0;
      end else begin
         slot_select <= next_slot_select;
         drv3_cfg    <= next_drv3_cfg;
         drv1_cfg    <= next_drv1_cfg;
         reg_rdata   <= next_reg_rdata;
         reg_rvalid  <= next_reg_rvalid;
      end
   end

   // the field outputs come straight from the register flops
   assign driver3_strength_bit = drv3_cfg[`LSD_SCALE_BIT];
   assign driver3_edge_speed   = drv3_cfg[`LSD_SLEW_LSB +: 3];
   assign driver3_coarse_code  = drv3_cfg[`LSD_COARSE_LSB +: 4];
   assign driver1_strength_bit = drv1_cfg[`LSD_SCALE_BIT];
   assign driver1_coarse_code  = drv1_cfg[`LSD_COARSE_LSB +: 4];

   always_comb begin
      next_driver1_coarse_term = lsd_pkg::lsd_coarse_term(driver1_coarse_code);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         driver1_coarse_term <= 12'h000;
      end else begin
         driver1_coarse_term <= next_driver1_coarse_term;
      end
   end

   // slot decoders: one per time slot
   logic [1:0] slot_choice [2];
   logic [3:0] slot_route  [2];
   logic [2:0] slot_enable [2];
   logic       slot_pulse  [2];
   logic [3:0] slot_out    [2];

   assign slot_choice[0] = slot_select[`LSD_FIRST_CHOICE_LSB +: 2];
   assign slot_choice[1] = slot_select[`LSD_SECOND_CHOICE_LSB +: 2];
   assign slot_route[0]  = slot_select[`LSD_FIRST_ROUTE_LSB +: 4];
   assign slot_route[1]  = slot_select[`LSD_SECOND_ROUTE_LSB +: 4];

   for (genvar s = 0; s < 2; s++) begin : g_slot
      localparam logic [1:0] RC = (s == 0) ? `LSD_RST_FIRST_CHOICE : `LSD_RST_SECOND_CHOICE;
      localparam logic [3:0] RR = (s == 0) ? `LSD_RST_FIRST_ROUTE : `LSD_RST_SECOND_ROUTE;
      lsd_slot_decode #(
         .RESET_CHOICE (RC),
         .RESET_ROUTE  (RR)
      ) u_decode (
         .clk                (clk),
         .rst                (rst),
         .emitter_choice     (slot_choice[s]),
         .detector_route_sel (slot_route[s]),
         .emitter_enable     (slot_enable[s]),
         .detector_pulse     (slot_pulse[s]),
         .detector_route     (slot_out[s])
      );
   end

   assign first_slot_emitter_enable  = slot_enable[0];
   assign first_slot_detector_pulse  = slot_pulse[0];
   assign first_slot_detector_route  = slot_out[0];
   assign second_slot_emitter_enable = slot_enable[1];
   assign second_slot_detector_pulse = slot_pulse[1];
   assign second_slot_detector_route = slot_out[1];

   // fine code comes from the adjust register outside this bank
   lsd_peak_calc u_peak3 (
      .clk          (clk),
      .rst          (rst),
      .coarse_code  (driver3_coarse_code),
      .fine_code    (driver3_fine_code),
      .strength_bit (driver3_strength_bit),
      .coarse_term  (driver3_coarse_term),
      .peak_target  (driver3_peak_target)
   );

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // separate model of the product, so a slip in the calc block shows
   logic [26:0] exp_peak;
   assign exp_peak = 27'(lsd_pkg::lsd_coarse_term(driver3_coarse_code))
                   * 27'(`LSD_FINE_BASE + `LSD_FINE_STEP * 11'(driver3_fine_code))
                   * (driver3_strength_bit ? 27'hA : 27'h1);

   a_first_emit_map: assert property (
      !$past(rst) |-> first_slot_emitter_enable
                      == lsd_pkg::lsd_emit_onehot($past(slot_select[1:0])))
      else $error("first slot emitter enable does not follow its code");

   a_second_emit_map: assert property (
      !$past(rst) |-> second_slot_emitter_enable
                      == lsd_pkg::lsd_emit_onehot($past(slot_select[3:2])))
      else $error("second slot emitter enable does not follow its code");

   a_detector_pulse_mode: assert property (
      !$past(rst) |-> (first_slot_detector_pulse == ($past(slot_select[1:0]) == 2'h0))
                   && (second_slot_detector_pulse == ($past(slot_select[3:2]) == 2'h0))
                   && !(first_slot_detector_pulse && first_slot_emitter_enable != 3'h0))
      else $error("detector pulse mode disagrees with emitter code");

   a_first_route_map: assert property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_SLOT_SELECT)
      |=> ##1 first_slot_detector_route == $past(reg_wdata[7:4], 2))
      else $error("first slot route not taken from write");

   a_second_route_map: assert property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_SLOT_SELECT)
      |=> ##1 second_slot_detector_route == $past(reg_wdata[11:8], 2))
      else $error("second slot route not taken from write");

   a_drv3_scale_write: assert property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_DRV3_CFG)
      |=> driver3_strength_bit == $past(reg_wdata[13]))
      else $error("driver 3 scale bit not updated by write");

   a_drv1_scale_write: assert property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_DRV1_CFG)
      |=> driver1_strength_bit == $past(reg_wdata[13]) && $stable(drv3_cfg))
      else $error("driver 1 scale bit not updated alone");

   a_drv3_slew_write: assert property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_DRV3_CFG)
      |=> driver3_edge_speed == $past(reg_wdata[6:4]))
      else $error("driver 3 slew field not updated by write");

   a_drv3_coarse_term: assert property (
      !$past(rst) |-> driver3_coarse_term
                      == 12'(16'h01F7 + 16'h00C6 * 16'($past(driver3_coarse_code))))
      else $error("driver 3 coarse term wrong");

   a_drv3_peak_value: assert property (
      !$past(rst) |-> 27'(driver3_peak_target) == $past(exp_peak))
      else $error("driver 3 peak target wrong");

   a_drv1_coarse_term: assert property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_DRV1_CFG)
      |=> ##1 driver1_coarse_term
              == 12'(16'h01F7 + 16'h00C6 * 16'($past(reg_wdata[3:0], 2))))
      else $error("driver 1 coarse term wrong");

   a_read_answer: assert property (
      reg_rd |=> reg_rvalid ##0 (reg_rdata == 16'h0000
                                 || $past(reg_addr) == ADDR_W'(`LSD_OFS_SLOT_SELECT)
                                 || $past(reg_addr) == ADDR_W'(`LSD_OFS_DRV3_CFG)
                                 || $past(reg_addr) == ADDR_W'(`LSD_OFS_DRV1_CFG)))
      else $error("read answer missing or unmapped data nonzero");

   a_reset_values: assert property (
      $past(rst) |-> slot_select == `LSD_RST_SLOT_SELECT
                  && drv3_cfg == `LSD_RST_DRV_CFG
                  && drv1_cfg == `LSD_RST_DRV_CFG
                  && first_slot_emitter_enable == 3'h1
                  && second_slot_detector_pulse
                  && first_slot_detector_route == `LSD_RST_FIRST_ROUTE
                  && second_slot_detector_route == `LSD_RST_SECOND_ROUTE)
      else $error("register bank left reset with wrong values");

   a_read_slot_word: assert property (
      reg_rd && reg_addr == ADDR_W'(`LSD_OFS_SLOT_SELECT)
      |=> reg_rdata == $past(slot_select))
      else $error("slot select word read back wrong");

   a_read_drv3_word: assert property (
      reg_rd && reg_addr == ADDR_W'(`LSD_OFS_DRV3_CFG)
      |=> reg_rdata == $past(drv3_cfg))
      else $error("driver 3 word read back wrong");

   // unmapped writes must not alias onto a mapped word
   a_unmapped_write: assert property (
      reg_wr && reg_addr != ADDR_W'(`LSD_OFS_SLOT_SELECT)
      && reg_addr != ADDR_W'(`LSD_OFS_DRV3_CFG)
      && reg_addr != ADDR_W'(`LSD_OFS_DRV1_CFG)
      |=> $stable(slot_select) && $stable(drv3_cfg) && $stable(drv1_cfg))
      else $error("write to an unmapped place changed a register");

   a_rvalid_pulse: assert property (
      reg_rvalid |-> $past(reg_rd))
      else $error("read answer without a read request");

   a_rdata_hold: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   c_detector_mode: cover property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_SLOT_SELECT) ##2 first_slot_detector_pulse);
   c_low_power_drv3: cover property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_DRV3_CFG) ##1 !driver3_strength_bit);
   c_driver3_slot_b: cover property (second_slot_emitter_enable == 3'h4);
   c_read_back: cover property (reg_rd ##1 reg_rvalid && reg_rdata != 16'h0000);
   c_low_power_drv1: cover property (
      reg_wr && reg_addr == ADDR_W'(`LSD_OFS_DRV1_CFG) ##1 !driver1_strength_bit);

endmodule : lsd_drive_config

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic        clk;
   logic        rst;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic [15:0] reg_wdata;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic [4:0]  fine_code;
   logic [2:0]  a_en;
   logic [2:0]  b_en;
   logic        a_pulse;
   logic        b_pulse;
   logic [3:0]  a_route;
   logic [3:0]  b_route;
   logic        d3_str;
   logic        d1_str;
   logic [2:0]  d3_slew;
   logic [3:0]  d3_coarse;
   logic [3:0]  d1_coarse;
   logic [11:0] d3_term;
   logic [11:0] d1_term;
   logic [25:0] d3_peak;
   logic [15:0] m14;
   logic [15:0] m22;
   logic [15:0] m23;
   logic [15:0] nxt;
   integer      failures;
   integer      n_checks;
   integer      seed;
   integer      cyc;

   lsd_drive_config #(.ADDR_W(8)) lsd_drive_config_inst (
      .clk                        (clk),
      .rst                        (rst),
      .reg_addr                   (reg_addr),
      .reg_wr                     (reg_wr),
      .reg_wdata                  (reg_wdata),
      .reg_rd                     (reg_rd),
      .reg_rdata                  (reg_rdata),
      .reg_rvalid                 (reg_rvalid),
      .driver3_fine_code          (fine_code),
      .first_slot_emitter_enable  (a_en),
      .first_slot_detector_pulse  (a_pulse),
      .first_slot_detector_route  (a_route),
      .second_slot_emitter_enable (b_en),
      .second_slot_detector_pulse (b_pulse),
      .second_slot_detector_route (b_route),
      .driver3_strength_bit       (d3_str),
      .driver3_edge_speed         (d3_slew),
      .driver3_coarse_code        (d3_coarse),
      .driver3_coarse_term        (d3_term),
      .driver3_peak_target        (d3_peak),
      .driver1_strength_bit       (d1_str),
      .driver1_coarse_code        (d1_coarse),
      .driver1_coarse_term        (d1_term)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [2:0] hot(input logic [1:0] c);
      case (c)
         2'h1:    return 3'h1;
         2'h2:    return 3'h2;
         2'h3:    return 3'h4;
         default: return 3'h0;
      endcase
   endfunction : hot

   // 0.1 mA units
   function automatic logic [11:0] term(input logic [3:0] c);
      return 12'(32'h1F7 + 32'hC6 * 32'(c));
   endfunction : term

   // 1e-5 mA units: coarse * fine(1e-3) * scale(0.1)
   function automatic logic [25:0] peak(input logic [3:0] c, input logic [4:0] f,
                                        input logic s);
      return 26'(32'(term(c)) * (32'h2E4 + 32'h16 * 32'(f)) * (s ? 32'hA : 32'h1));
   endfunction : peak

   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [25:0] got, input logic [25:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      // answer stands for one cycle only
      #1;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, exp);
   endtask : rd

   // fields must settle one edge behind the register
   task automatic check_all();
      repeat (3) @(posedge clk);
      #1;
      chk(a_en, hot(m14[1:0]));
      chk(a_pulse, m14[1:0] == 2'h0);
      chk(a_route, m14[7:4]);
      chk(b_en, hot(m14[3:2]));
      chk(b_pulse, m14[3:2] == 2'h0);
      chk(b_route, m14[11:8]);
      chk(d3_str, m22[13]);
      chk(d3_slew, m22[6:4]);
      chk(d3_coarse, m22[3:0]);
      chk(d3_term, term(m22[3:0]));
      chk(d3_peak, peak(m22[3:0], fine_code, m22[13]));
      chk(d1_str, m23[13]);
      chk(d1_coarse, m23[3:0]);
      chk(d1_term, term(m23[3:0]));
   endtask : check_all

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc >= 6000) begin
         failures = failures + 1;
         end_of_test();
      end
   end

   initial begin
      failures  = 0;
      n_checks  = 0;
      seed      = 37;
      cyc       = 0;
      rst       = 1'b1;
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd    = 1'b0;
      fine_code = 5'h00;
      m14       = 16'h0541;
      m22       = 16'h3000;
      m23       = 16'h3000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(8'h14, 16'h0541);
      rd(8'h22, 16'h3000);
      rd(8'h23, 16'h3000);
      check_all();
      // every emitter code in both slots, upper bits kept zero
      for (int i = 0; i < 16; i++) begin
         nxt = 16'($random(seed));
         m14 = {4'h0, nxt[11:4], 4'(i)};
         wr(8'h14, m14);
         check_all();
         rd(8'h14, m14);
      end
      // driver settings, extremes first, reserved bits at defaults
      for (int i = 0; i < 24; i++) begin
         nxt = 16'($random(seed));
         if (i == 0) nxt = 16'hFFFF;
         if (i == 1) nxt = 16'h0000;
         m22 = {2'h0, nxt[13], 1'h1, 5'h00, nxt[6:0]};
         m23 = {2'h0, nxt[12], 1'h1, 5'h00, 3'h0, nxt[11:8]};
         wr(8'h22, m22);
         fine_code <= nxt[15:11];
         wr(8'h23, m23);
         check_all();
         rd(8'h22, m22);
         rd(8'h23, m23);
      end
      // unmapped place: write ignored, read answers zero
      wr(8'h30, 16'($random(seed)));
      rd(8'h30, 16'h0000);
      rd(8'h22, m22);
      // write and read together return the old word
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b1;
      reg_addr  <= 8'h23;
      reg_wdata <= 16'h1005;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
      chk(reg_rdata, m23);
      m23 = 16'h1005;
      check_all();
      end_of_test();
   end
endmodule : testbench
